// ===== core/pscr_defs.vh
`ifndef PSCR_DEFS_VH
`define PSCR_DEFS_VH

// Register byte addresses
`define PSCR_ADDR_POWER 12'h19C
`define PSCR_ADDR_RULE_SEL 12'h1A0
`define PSCR_ADDR_RULE_PAT 12'h1A4
`define PSCR_ADDR_MATCH_CTL 12'h1B0
`define PSCR_ADDR_IRQ_STAT 12'h1B4
`define PSCR_ADDR_IRQ_MASK 12'h1B8

// Power state register fields
`define PSCR_PWR_MARGIN1_LSB 22
`define PSCR_PWR_MARGIN2_LSB 20
`define PSCR_PWR_MARGIN3_LSB 18
`define PSCR_PWR_FLAG_BIT 15
`define PSCR_PWR_ENABLE_BIT 8
`define PSCR_PWR_STATE_LSB 0
`define PSCR_STATE_FULL 2'h0
`define PSCR_MARGIN_RESET 2'h0

// Rule address field
`define PSCR_SEL_LSB 0
`define PSCR_SEL_W 7
`define PSCR_ENTRIES 128

// Rule match pattern fields
`define PSCR_PAT_PMASK_LSB 25
`define PSCR_PAT_PMATCH_LSB 17
`define PSCR_PAT_DMASK_LSB 8
`define PSCR_PAT_DMATCH_LSB 0
`define PSCR_PAT_RW_MASK 32'hFEFEFFFF
`define PSCR_PAT_RESET 32'hFE3EFF00

// Match control encodings
`define PSCR_MC_DONE 2'h0
`define PSCR_MC_DATA 2'h2
`define PSCR_MC_XREG 2'h1
`define PSCR_MC_DROP 2'h3
`define PSCR_MC_RESET 2'h2

// Interrupt status bits
`define PSCR_IRQ_WAKE_BIT 0
`define PSCR_IRQ_HIT_BIT 1
`define PSCR_IRQ_W 2

`endif

// ===== core/pscr_regs.v
// What this block does
// - A wake from the CAM outside full power sets the power event flag; writing one clears it.
// - The power event output is driven only while the enable bit 8 is set.
// - Host writes the two-bit power state; any non-zero value means power down.
// - Outside full power, wake signals may raise power event interrupts.
// - Outside full power, receive data transfer into queues is blocked.
// - Three read-write two-bit regulator margins, reset 00, drive their regulators.
// - Seven-bit rule address, reset zero, selects the CAM entry accessed.
// - Seven-bit previous-hit mask, reset 0x7F, zero bits are don't-care.
// - Seven-bit previous-hit match, reset 0x1F, compared with last pass hit address.
// - Eight-bit data mask, reset 0xFF, zero bits are don't-care.
// - Data match compares packet byte or X register, chosen by match control.
// - An entry whose previous-hit mask is all zero never hits.
// - Two-bit match control per rule: 00 done, 10 data, 01 X, 11 drop; reset 10.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "pscr_defs.vh"

module pscr_regs (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire pclken,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Classifier pass
    input wire cam_pass_valid,
    input wire [7:0] cam_pass_byte,
    input wire [7:0] cam_pass_xreg,
    input wire cam_wake,
    output reg cam_hit_valid,
    output reg cam_hit,
    output reg [6:0] cam_hit_addr,
    output reg [1:0] cam_hit_ctrl,
    // Power management
    output wire power_event,
    output wire rx_queue_inhibit,
    output wire [1:0] regulator_margin_one,
    output wire [1:0] regulator_margin_two,
    output wire [1:0] regulator_margin_three,
    // Interrupt
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////
    // Compare one CAM entry against the current pass
    function entry_hits;
        input [31:0] pat;
        input [1:0] mc;
        input [6:0] prev;
        input [7:0] pbyte;
        input [7:0] xval;
        reg [6:0] pmask;
        reg [6:0] pmatch;
        reg [7:0] dmask;
        reg [7:0] dmatch;
        reg [7:0] ref_word;
        reg prev_ok;
        reg data_ok;
        begin
            pmask = pat[`PSCR_PAT_PMASK_LSB +: 7];
            pmatch = pat[`PSCR_PAT_PMATCH_LSB +: 7];
            dmask = pat[`PSCR_PAT_DMASK_LSB +: 8];
            dmatch = pat[`PSCR_PAT_DMATCH_LSB +: 8];
            // X register only for its own encoding; other settings compare the byte
            ref_word = (mc == `PSCR_MC_XREG) ? xval : pbyte;
            prev_ok = (((prev ^ pmatch) & pmask) == 7'h00);
            data_ok = (((ref_word ^ dmatch) & dmask) == 8'h00);
            entry_hits = (pmask != 7'h00) && prev_ok && data_ok;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    reg [1:0] margin1_reg;
    reg [1:0] margin2_reg;
    reg [1:0] margin3_reg;
    reg flag_reg;
    reg enable_reg;
    reg [1:0] state_reg;
    reg [6:0] sel_reg;
    reg [6:0] prev_hit_reg;
    reg [`PSCR_IRQ_W-1:0] irq_stat_reg;
    reg [`PSCR_IRQ_W-1:0] irq_mask_reg;
    reg [31:0] pat_mem [0:`PSCR_ENTRIES-1];
    reg [1:0] mc_mem [0:`PSCR_ENTRIES-1];

    reg flag_next;
    reg [`PSCR_IRQ_W-1:0] irq_stat_next;
    reg found;
    reg [6:0] found_addr;
    integer i;
    // Separate loop index so the reset loop and the search do not share a variable
    integer j;

    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire power_down;
    wire wake_ok;
    wire hit_event;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; every access completes in its first access cycle
    assign pready = 1'b1;
    assign addr_ok = (paddr == `PSCR_ADDR_POWER) || (paddr == `PSCR_ADDR_RULE_SEL) ||
                     (paddr == `PSCR_ADDR_RULE_PAT) || (paddr == `PSCR_ADDR_MATCH_CTL) ||
                     (paddr == `PSCR_ADDR_IRQ_STAT) || (paddr == `PSCR_ADDR_IRQ_MASK);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok && pclken;
    assign rd_en = psel && penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Power state decoding
    assign power_down = (state_reg != `PSCR_STATE_FULL);
    assign rx_queue_inhibit = power_down;
    // Wakes in full power are ignored so a running host is not disturbed
    assign wake_ok = cam_wake && power_down;
    assign power_event = flag_reg && enable_reg;
    assign regulator_margin_one = margin1_reg;
    assign regulator_margin_two = margin2_reg;
    assign regulator_margin_three = margin3_reg;
    assign hit_event = cam_pass_valid && found;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the clearing cycle wins
    always @* begin
        flag_next = flag_reg;
        if (wr_en && (paddr == `PSCR_ADDR_POWER) && pwdata[`PSCR_PWR_FLAG_BIT]) begin
            flag_next = 1'b0;
        end
        if (wake_ok) begin
            flag_next = 1'b1;
        end
    end

    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_en && (paddr == `PSCR_ADDR_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~pwdata[`PSCR_IRQ_W-1:0];
        end
        if (wake_ok) begin
            irq_stat_next[`PSCR_IRQ_WAKE_BIT] = 1'b1;
        end
        if (hit_event) begin
            irq_stat_next[`PSCR_IRQ_HIT_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel CAM search; the lowest matching entry wins
    always @* begin
        found = 1'b0;
        found_addr = 7'h00;
        for (i = `PSCR_ENTRIES - 1; i >= 0; i = i - 1) begin
            if (entry_hits(pat_mem[i], mc_mem[i], prev_hit_reg, cam_pass_byte, cam_pass_xreg)) begin
                found = 1'b1;
                found_addr = i[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            margin1_reg <= `PSCR_MARGIN_RESET;
            margin2_reg <= `PSCR_MARGIN_RESET;
            margin3_reg <= `PSCR_MARGIN_RESET;
            flag_reg <= 1'b0;
            enable_reg <= 1'b0;
            state_reg <= `PSCR_STATE_FULL;
            sel_reg <= 7'h00;
            irq_stat_reg <= {`PSCR_IRQ_W{1'b0}};
            irq_mask_reg <= {`PSCR_IRQ_W{1'b0}};
        end else if (pclken) begin
            flag_reg <= flag_next;
            irq_stat_reg <= irq_stat_next;
            if (wr_en && (paddr == `PSCR_ADDR_POWER)) begin
                margin1_reg <= pwdata[`PSCR_PWR_MARGIN1_LSB +: 2];
                margin2_reg <= pwdata[`PSCR_PWR_MARGIN2_LSB +: 2];
                margin3_reg <= pwdata[`PSCR_PWR_MARGIN3_LSB +: 2];
                enable_reg <= pwdata[`PSCR_PWR_ENABLE_BIT];
                state_reg <= pwdata[`PSCR_PWR_STATE_LSB +: 2];
            end
            if (wr_en && (paddr == `PSCR_ADDR_RULE_SEL)) begin
                sel_reg <= pwdata[`PSCR_SEL_LSB +: `PSCR_SEL_W];
            end
            if (wr_en && (paddr == `PSCR_ADDR_IRQ_MASK)) begin
                irq_mask_reg <= pwdata[`PSCR_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rule storage; reset loads every entry so no entry starts half defined
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < `PSCR_ENTRIES; j = j + 1) begin
                pat_mem[j] <= `PSCR_PAT_RESET;
                mc_mem[j] <= `PSCR_MC_RESET;
            end
        end else if (pclken) begin
            if (wr_en && (paddr == `PSCR_ADDR_RULE_PAT)) begin
                pat_mem[sel_reg] <= pwdata & `PSCR_PAT_RW_MASK;
            end
            if (wr_en && (paddr == `PSCR_ADDR_MATCH_CTL)) begin
                mc_mem[sel_reg] <= pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pass results; a miss keeps the previous hit address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_hit_reg <= 7'h00;
            cam_hit_valid <= 1'b0;
            cam_hit <= 1'b0;
            cam_hit_addr <= 7'h00;
            cam_hit_ctrl <= `PSCR_MC_DONE;
        end else if (pclken) begin
            cam_hit_valid <= cam_pass_valid;
            if (cam_pass_valid) begin
                cam_hit <= found;
                cam_hit_addr <= found_addr;
                cam_hit_ctrl <= found ? mc_mem[found_addr] : `PSCR_MC_DONE;
                if (found) begin
                    prev_hit_reg <= found_addr;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured during the setup cycle so it is ready at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (pclken) begin
            if (psel && !penable && !pwrite) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `PSCR_ADDR_POWER: begin
                        prdata[`PSCR_PWR_MARGIN1_LSB +: 2] <= margin1_reg;
                        prdata[`PSCR_PWR_MARGIN2_LSB +: 2] <= margin2_reg;
                        prdata[`PSCR_PWR_MARGIN3_LSB +: 2] <= margin3_reg;
                        prdata[`PSCR_PWR_FLAG_BIT] <= flag_next;
                        prdata[`PSCR_PWR_ENABLE_BIT] <= enable_reg;
                        prdata[`PSCR_PWR_STATE_LSB +: 2] <= state_reg;
                    end
                    `PSCR_ADDR_RULE_SEL: begin
                        prdata[`PSCR_SEL_LSB +: `PSCR_SEL_W] <= sel_reg;
                    end
                    // Entries zero and one read back whatever is stored
                    `PSCR_ADDR_RULE_PAT: begin
                        prdata <= pat_mem[sel_reg];
                    end
                    `PSCR_ADDR_MATCH_CTL: begin
                        prdata[1:0] <= mc_mem[sel_reg];
                    end
                    `PSCR_ADDR_IRQ_STAT: begin
                        prdata[`PSCR_IRQ_W-1:0] <= irq_stat_next;
                    end
                    `PSCR_ADDR_IRQ_MASK: begin
                        prdata[`PSCR_IRQ_W-1:0] <= irq_mask_reg;
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end else if (rd_en) begin
                prdata <= prdata;
            end
        end
    end

endmodule // pscr_regs

// ===== verif/pscr_host_model.sv
`timescale 1ns/1ps
// Host side of the power event line: counts each new event it is woken by
module pscr_host_model (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Event from the device
    input logic power_event,
    output int wake_count
);
    logic seen_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_reg <= 1'b0;
            wake_count <= 0;
        end else begin
            seen_reg <= power_event;
            if (power_event && !seen_reg) wake_count <= wake_count + 1;
        end
    end
endmodule // pscr_host_model

// ===== verif/pscr_regs_asserts.sv
`timescale 1ns/1ps
module pscr_regs_asserts (
    // Clock, reset and bus
    input logic pclk, presetn, pclken, psel, penable, pwrite,
    input logic [11:0] paddr,
    // Classifier and power outputs
    input logic cam_pass_valid, cam_wake, cam_hit_valid, cam_hit, power_event, rx_queue_inhibit,
    input logic [1:0] cam_hit_ctrl, regulator_margin_one, regulator_margin_two, regulator_margin_three
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire any_wr = psel && penable && pwrite;
    wire pwr_wr = any_wr && paddr == 12'h19C;
    sequence s_pass; cam_pass_valid && pclken; endsequence
    sequence s_idle; cam_hit_valid && pclken && !cam_pass_valid; endsequence
    AST_EVENT_RISE: assert property ($rose(power_event) |-> $past(cam_wake && rx_queue_inhibit) || $past(pwr_wr))
        else $error("power event rose without cause");
    AST_EVENT_HOLD: assert property (power_event && !any_wr |=> power_event)
        else $error("power event dropped without write");
    AST_WAKE_IGNORED: assert property (cam_wake && !rx_queue_inhibit && !power_event && !any_wr |=> !power_event)
        else $error("wake in full power raised event");
    AST_INHIBIT_STABLE: assert property (!pwr_wr |=> $stable(rx_queue_inhibit))
        else $error("queue inhibit moved without write");
    AST_MARGIN_STABLE: assert property (!pwr_wr |=>
        $stable({regulator_margin_one, regulator_margin_two, regulator_margin_three}))
        else $error("margin moved without write");
    AST_HIT_PULSE: assert property (s_pass |=> cam_hit_valid)
        else $error("pass gave no result");
    AST_HIT_ONE_CYCLE: assert property (s_idle |=> !cam_hit_valid)
        else $error("result pulse too long");
    AST_MISS_CTRL: assert property (cam_hit_valid && !cam_hit |-> cam_hit_ctrl == 2'h0)
        else $error("miss carried control code");
endmodule // pscr_regs_asserts
bind pscr_regs pscr_regs_asserts i_chk (.*);

// ===== verif/pscr_regs_tb.sv
`timescale 1ns/1ps
`include "pscr_defs.vh"
module pscr_regs_tb;
    logic pclk = 0, presetn = 0, pclken = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, d;
    logic pready, pslverr, cam_pass_valid = 0, cam_wake = 0, cam_hit_valid, cam_hit;
    logic power_event, rx_queue_inhibit, irq;
    logic [7:0] cam_pass_byte = 0, cam_pass_xreg = 0, b;
    logic [6:0] cam_hit_addr, prev_m;
    logic [1:0] cam_hit_ctrl, regulator_margin_one, regulator_margin_two, regulator_margin_three;
    logic [31:0] pat_m [128];
    logic [1:0] mc_m [128];
    logic [15:0] lfsr = 16'h0054;
    int mismatches = 0, num_checks = 0, cycles = 0, wakes, e;
    pscr_regs i_dut (.*);
    pscr_host_model i_host (.pclk(pclk), .presetn(presetn), .power_event(power_event), .wake_count(wakes));
    always #5 pclk = ~pclk;
    // Hang guard, far above the roughly two hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////
    function logic [7:0] rnd;
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; an idle cycle follows so no signal is driven twice in a step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task prog(input int i, input logic [31:0] p, input logic [1:0] c);
        apb(1, `PSCR_ADDR_RULE_SEL, i);
        apb(1, `PSCR_ADDR_RULE_PAT, p | 32'h01010000);
        apb(1, `PSCR_ADDR_MATCH_CTL, c);
        apb(0, `PSCR_ADDR_RULE_PAT, 0);
        check(rd, p);
        pat_m[i] = p;
        mc_m[i] = c;
    endtask
    // Reference CAM: lowest enabled entry whose masked fields both agree
    task pass(input logic [7:0] pb, input logic [7:0] px);
        logic [31:0] p;
        logic [7:0] v;
        e = -1;
        for (int i = 127; i >= 0; i--) begin
            p = pat_m[i];
            v = (mc_m[i] == `PSCR_MC_XREG) ? px : pb;
            if (p[31:25] != 0 && ((p[23:17] ^ prev_m) & p[31:25]) == 0 && ((p[7:0] ^ v) & p[15:8]) == 0) e = i;
        end
        cam_pass_valid <= 1'b1;
        cam_pass_byte <= pb;
        cam_pass_xreg <= px;
        @(posedge pclk);
        cam_pass_valid <= 1'b0;
        // Result pulse stands only in the cycle after the pass edge
        @(negedge pclk);
        check(cam_hit_valid, 1);
        check(cam_hit, e >= 0);
        check(cam_hit_ctrl, e >= 0 ? mc_m[e] : 2'h0);
        if (e >= 0) check(cam_hit_addr, e[6:0]);
        if (e >= 0) prev_m = e[6:0];
        @(posedge pclk);
    endtask
    task wake;
        cam_wake <= 1'b1;
        @(posedge pclk);
        cam_wake <= 1'b0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 128; i++) begin
            pat_m[i] = `PSCR_PAT_RESET;
            mc_m[i] = `PSCR_MC_RESET;
        end
        prev_m = 7'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `PSCR_ADDR_POWER, 0);
        check(rd, 0);
        apb(0, `PSCR_ADDR_RULE_SEL, 0);
        check(rd, 0);
        // Entries zero and one are skipped, their contents are not trusted
        apb(1, `PSCR_ADDR_RULE_SEL, 5);
        apb(0, `PSCR_ADDR_RULE_PAT, 0);
        check(rd, 32'hFE3EFF00);
        apb(0, `PSCR_ADDR_MATCH_CTL, 0);
        check(rd, 2);
        apb(0, 12'hFFC, 0);
        check(err, 1);
        check(rd, 0);
        for (int s = 0; s < 4; s++) begin
            d = (({24'h000000, rnd()}) << 18) & 32'h00FC0000 | s;
            apb(1, `PSCR_ADDR_POWER, d);
            check({regulator_margin_one, regulator_margin_two, regulator_margin_three}, d[23:18]);
            check(rx_queue_inhibit, s != 0);
            apb(0, `PSCR_ADDR_POWER, 0);
            check(rd, d);
        end
        apb(1, `PSCR_ADDR_POWER, 32'h00000100);
        wake;
        check(power_event, 0);
        apb(1, `PSCR_ADDR_IRQ_MASK, 3);
        apb(1, `PSCR_ADDR_POWER, 32'h00000101);
        wake;
        check({power_event, irq}, 2'h3);
        apb(1, `PSCR_ADDR_IRQ_MASK, 2);
        check(irq, 0);
        apb(0, `PSCR_ADDR_POWER, 0);
        check(rd, 32'h00008101);
        apb(1, `PSCR_ADDR_POWER, 32'h00000001);
        check(power_event, 0);
        apb(1, `PSCR_ADDR_POWER, 32'h00000101);
        check(power_event, 1);
        apb(1, `PSCR_ADDR_POWER, 32'h00008101);
        check({power_event, wakes[1:0]}, 3'h2);
        apb(1, `PSCR_ADDR_IRQ_STAT, 3);
        // Classification passes against the reference CAM
        pass(8'h00, 8'h00);
        e = 2 + 2 * (rnd() % 60);
        b = rnd();
        prog(e, {7'h00, 1'b0, 7'h00, 1'b0, 8'hF0, b}, `PSCR_MC_DATA);
        pass(b, ~b);
        prog(e, {7'h01, 1'b0, 7'h00, 1'b0, 8'hF0, b}, `PSCR_MC_DATA);
        pass(b ^ 8'h0F, ~b);
        prog(e, {7'h01, 1'b0, 7'h00, 1'b0, 8'hF0, b}, `PSCR_MC_XREG);
        pass(~b, b);
        prog(e + 1, {7'h7F, 1'b0, e[6:0], 1'b0, 8'h00, 8'h00}, `PSCR_MC_DROP);
        pass(~b, ~b);
        pass(~b, ~b);
        for (int c = 0; c < 4; c++) begin
            apb(1, `PSCR_ADDR_MATCH_CTL, c);
            mc_m[e + 1] = c;
            apb(0, `PSCR_ADDR_MATCH_CTL, 0);
            check(rd, c);
        end
        repeat (20) pass(rnd(), rnd());
        apb(0, `PSCR_ADDR_IRQ_STAT, 0);
        check(irq, 1);
        check(rd, 2);
        apb(1, `PSCR_ADDR_IRQ_STAT, 2);
        check(irq, 0);
        // Clock enable low freezes state: a wake in low power is lost
        pclken <= 1'b0;
        wake;
        pclken <= 1'b1;
        @(posedge pclk);
        check(power_event, 0);
        give_verdict;
    end
endmodule // pscr_regs_tb
